// ### hw/mac_txrx_control_status.v
// MAC transmit and receive control and status logic with AXI4-Lite registers.
//
// Function
// - Jabber off bit stops 2048-byte transmit limit.
// - Abort after 16 collisions unless retry set.
// - Per-slot pad and FCS disable bits.
// - Go bit starts send, self-clears when done.
// - Separate status register per transmit slot.
// - Flag jabber timeout on truncated frame.
// - Flag carrier loss during transmit.
// - Flag carrier never present during transmit.
// - Flag collision after 64-byte window.
// - Flag any collision in slot status.
// - Flag transmit aborted after 16 collisions.
// - Watchdog off bit stops 2048-byte receive limit.
// - Drop received frames over 1522 bytes.
// - Drop received frames with bad FCS.
// - Flag received frame under 64 bytes.
// - Flag received multicast destination.
// - Flag late collision during reception.
// - Flag reception longer than 2048 bytes.
// - Flag PHY symbol error during reception.
// - Flag frame ending off byte boundary.
// - Flag received frame with bad FCS.
// - Flag receive FIFO overflow during frame.
//
// Chosen here: the AXI4-Lite register port.
`include "mac_txrx_regs.vh"
module mac_txrx_control_status (
  input wire clk,
  input wire rst,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire carrierPin,
  input wire symbolErrPin,
  input wire loopbackOn,
  input wire txByteSent,
  input wire txFrameEnd,
  input wire txCollision,
  output reg txStart,
  output reg txSlotTwo,
  output reg txPadOn,
  output reg txFcsOn,
  output reg txRetry,
  output reg txCut,
  output reg txDone,
  input wire rxFrameStart,
  input wire rxByteSeen,
  input wire rxFrameEnd,
  input wire rxCollision,
  input wire rxFifoOverrun,
  input wire rxGroupAddr,
  input wire rxAddrMatch,
  input wire rxFcsBad,
  input wire rxDribble,
  output reg rxActive,
  output reg rxCut,
  output reg rxAccept,
  output reg rxDrop
);
  localparam [1:0] T_IDLE = 2'b01;
  localparam [1:0] T_SEND = 2'b10;
  localparam [1:0] R_IDLE = 2'b01;
  localparam [1:0] R_RECV = 2'b10;

  reg [7:0] txCtrl_r;
  reg [7:0] txStat1_r;
  reg [7:0] txStat2_r;
  reg [7:0] rxCtrl_r;
  reg [7:0] rxStat_r;
  reg awHeld_r;
  reg [5:0] awIdx_r;
  reg wHeld_r;
  reg [7:0] wByte_r;
  reg wLane_r;
  reg crsMeta_r;
  reg crsSync_r;
  reg symMeta_r;
  reg symSync_r;
  reg [1:0] txState_r;
  reg [11:0] txBytes_r;
  reg [4:0] txColls_r;
  reg txSlot_r;
  reg carrierSeen_r;
  reg fJab_r;
  reg fLost_r;
  reg fLate_r;
  reg fCol_r;
  reg fExc_r;
  reg [1:0] rxState_r;
  reg [11:0] rxBytes_r;
  reg fRxLate_r;
  reg fRxWd_r;
  reg fRxSym_r;
  reg fRxOvr_r;

  function mapped;
    input [5:0] idx;
    begin
      mapped = (idx >= `IDX_TXCTRL) && (idx <= `IDX_RXSTAT);
    end
  endfunction

  function [11:0] bump;
    input [11:0] cnt;
    begin
      bump = (cnt == `BYTES_SAT) ? cnt : cnt + `BYTES_ONE;
    end
  endfunction

  wire wrFire = awHeld_r & wHeld_r & ~bvalid;
  wire wrCtl = wrFire & wLane_r;
  wire goBit = txCtrl_r[`TXC_GO];
  wire jabOff = txCtrl_r[`TXC_JABOFF];
  wire retryOn = txCtrl_r[`TXC_RETRY];
  wire sending = txState_r == T_SEND;
  wire collAbort = sending & txCollision & ~retryOn &
    (txColls_r == `COLL_MAX);
  wire jabHit = sending & txByteSent & ~jabOff &
    (txBytes_r == `JABBER_BYTES);
  wire txFinish = collAbort | jabHit |
    (sending & txFrameEnd & ~txCollision);
  wire carrierNow = crsSync_r;
  wire lostNow = fLost_r | (carrierSeen_r & ~carrierNow);
  // Carrier indications are forced low in loopback, where they mean nothing.
  wire [7:0] txStatNew = {fJab_r | jabHit,
    lostNow & ~loopbackOn,
    ~(carrierSeen_r | carrierNow) & ~loopbackOn,
    fLate_r | (txCollision & (txBytes_r >= `WINDOW_BYTES)),
    fCol_r | txCollision,
    fExc_r | collAbort,
    2'b00};
  wire receiving = rxState_r == R_RECV;
  wire wdHit = receiving & rxByteSeen & ~rxCtrl_r[`RXC_WDOFF] &
    (rxBytes_r == `JABBER_BYTES);
  wire rxFinish = wdHit | (receiving & rxFrameEnd);
  wire isRunt = rxBytes_r < `WINDOW_BYTES;
  wire isLong = rxBytes_r > `MAX_FRAME;
  wire [7:0] rxStatNew = {isRunt,
    rxGroupAddr,
    fRxLate_r | (rxCollision & (rxBytes_r >= `WINDOW_BYTES)),
    fRxWd_r | wdHit,
    fRxSym_r | symSync_r,
    rxDribble,
    rxFcsBad,
    fRxOvr_r | rxFifoOverrun};
  wire addrPass = rxAddrMatch | rxCtrl_r[`RXC_PROM] |
    (rxGroupAddr & rxCtrl_r[`RXC_ALLMC]);
  wire dropIt = (isLong & rxCtrl_r[`RXC_DROPLONG]) |
    (rxFcsBad & rxCtrl_r[`RXC_DROPFCS]) |
    (isRunt & ~rxCtrl_r[`RXC_RUNT]) |
    ~addrPass | wdHit | fRxOvr_r | rxFifoOverrun;

  // Pins from the PHY are not on this clock, so each gets two flops.
  always @(posedge clk)
  begin
    if (rst)
    begin
      crsMeta_r <= 1'b0;
      crsSync_r <= 1'b0;
      symMeta_r <= 1'b0;
      symSync_r <= 1'b0;
    end
    else
    begin
      crsMeta_r <= carrierPin;
      crsSync_r <= crsMeta_r;
      symMeta_r <= symbolErrPin;
      symSync_r <= symMeta_r;
    end
  end

  // Write channel. Address and data are taken in either order and held.
  always @(posedge clk)
  begin
    if (rst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awIdx_r <= 6'h00;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid & awready)
      begin
        awHeld_r <= 1'b1;
        awIdx_r <= awaddr[7:2];
        awready <= 1'b0;
      end
      if (wvalid & wready)
      begin
        wHeld_r <= 1'b1;
        wByte_r <= wdata[7:0];
        wLane_r <= wstrb[0];
        wready <= 1'b0;
      end
      if (wrFire)
      begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(awIdx_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid & bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always @(posedge clk)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid & arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= mapped(araddr[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
      case (araddr[7:2])
        `IDX_TXCTRL: rdata <= {24'h000000, txCtrl_r};
        `IDX_TXSTAT1: rdata <= {24'h000000, txStat1_r};
        `IDX_TXSTAT2: rdata <= {24'h000000, txStat2_r};
        `IDX_RXCTRL: rdata <= {24'h000000, rxCtrl_r};
        `IDX_RXSTAT: rdata <= {24'h000000, rxStat_r};
        default: rdata <= 32'h00000000;
      endcase
    end
    else if (rvalid & rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // A software write of go in the finishing cycle wins over the auto clear.
  always @(posedge clk)
  begin
    if (rst)
    begin
      txCtrl_r <= `CTRL_RESET;
      rxCtrl_r <= `CTRL_RESET;
    end
    else
    begin
      if (wrCtl && awIdx_r == `IDX_TXCTRL)
      begin
        txCtrl_r <= (wByte_r & `CTRL_WMASK) |
          {7'h00, goBit & ~txFinish};
      end
      else if (txFinish)
      begin
        txCtrl_r[`TXC_GO] <= 1'b0;
      end
      if (wrCtl && awIdx_r == `IDX_RXCTRL)
      begin
        rxCtrl_r <= wByte_r & `CTRL_WMASK;
      end
    end
  end

  // Transmit sequencer. Slots alternate, one then two, after each frame.
  always @(posedge clk)
  begin
    if (rst)
    begin
      txState_r <= T_IDLE;
      txBytes_r <= `BYTES_ZERO;
      txColls_r <= `COLL_ZERO;
      txSlot_r <= 1'b0;
      carrierSeen_r <= 1'b0;
      fJab_r <= 1'b0;
      fLost_r <= 1'b0;
      fLate_r <= 1'b0;
      fCol_r <= 1'b0;
      fExc_r <= 1'b0;
      txStat1_r <= `STAT_RESET;
      txStat2_r <= `STAT_RESET;
      txStart <= 1'b0;
      txSlotTwo <= 1'b0;
      txPadOn <= 1'b1;
      txFcsOn <= 1'b1;
      txRetry <= 1'b0;
      txCut <= 1'b0;
      txDone <= 1'b0;
    end
    else
    begin
      txStart <= 1'b0;
      txRetry <= 1'b0;
      txCut <= 1'b0;
      txDone <= 1'b0;
      case (txState_r)
        T_IDLE:
        begin
          if (goBit)
          begin
            txState_r <= T_SEND;
            txStart <= 1'b1;
            txSlotTwo <= txSlot_r;
            txPadOn <= ~(txSlot_r ? txCtrl_r[`TXC_S2PAD] :
              txCtrl_r[`TXC_S1PAD]);
            txFcsOn <= ~(txSlot_r ? txCtrl_r[`TXC_S2FCS] :
              txCtrl_r[`TXC_S1FCS]);
            txBytes_r <= `BYTES_ZERO;
            txColls_r <= `COLL_ZERO;
            carrierSeen_r <= 1'b0;
            fJab_r <= 1'b0;
            fLost_r <= 1'b0;
            fLate_r <= 1'b0;
            fCol_r <= 1'b0;
            fExc_r <= 1'b0;
          end
        end
        T_SEND:
        begin
          if (carrierNow)
          begin
            carrierSeen_r <= 1'b1;
          end
          fLost_r <= lostNow;
          if (txFinish)
          begin
            txState_r <= T_IDLE;
            txDone <= 1'b1;
            txCut <= collAbort | jabHit;
            txSlot_r <= ~txSlot_r;
            if (txSlot_r)
            begin
              txStat2_r <= txStatNew;
            end
            else
            begin
              txStat1_r <= txStatNew;
            end
          end
          else if (txCollision)
          begin
            fCol_r <= 1'b1;
            if (txBytes_r >= `WINDOW_BYTES)
            begin
              fLate_r <= 1'b1;
            end
            if (txColls_r != `COLL_SAT)
            begin
              txColls_r <= txColls_r + `COLL_ONE;
            end
            txBytes_r <= `BYTES_ZERO;
            txRetry <= 1'b1;
          end
          else if (txByteSent)
          begin
            txBytes_r <= bump(txBytes_r);
          end
        end
        default:
        begin
          txState_r <= T_IDLE;
        end
      endcase
    end
  end

  // Receive tracker. A frame started while reception is off is ignored.
  always @(posedge clk)
  begin
    if (rst)
    begin
      rxState_r <= R_IDLE;
      rxBytes_r <= `BYTES_ZERO;
      fRxLate_r <= 1'b0;
      fRxWd_r <= 1'b0;
      fRxSym_r <= 1'b0;
      fRxOvr_r <= 1'b0;
      rxStat_r <= `STAT_RESET;
      rxActive <= 1'b0;
      rxCut <= 1'b0;
      rxAccept <= 1'b0;
      rxDrop <= 1'b0;
    end
    else
    begin
      rxCut <= 1'b0;
      rxAccept <= 1'b0;
      rxDrop <= 1'b0;
      case (rxState_r)
        R_IDLE:
        begin
          if (rxFrameStart & rxCtrl_r[`RXC_EN])
          begin
            rxState_r <= R_RECV;
            rxActive <= 1'b1;
            rxBytes_r <= `BYTES_ZERO;
            fRxLate_r <= 1'b0;
            fRxWd_r <= 1'b0;
            fRxSym_r <= 1'b0;
            fRxOvr_r <= 1'b0;
          end
        end
        R_RECV:
        begin
          if (rxFinish)
          begin
            rxState_r <= R_IDLE;
            rxActive <= 1'b0;
            rxCut <= wdHit;
            rxStat_r <= rxStatNew;
            rxAccept <= ~dropIt;
            rxDrop <= dropIt;
          end
          else
          begin
            if (rxByteSeen)
            begin
              rxBytes_r <= bump(rxBytes_r);
            end
            if (rxCollision && rxBytes_r >= `WINDOW_BYTES)
            begin
              fRxLate_r <= 1'b1;
            end
            if (symSync_r)
            begin
              fRxSym_r <= 1'b1;
            end
            if (rxFifoOverrun)
            begin
              fRxOvr_r <= 1'b1;
            end
          end
        end
        default:
        begin
          rxState_r <= R_IDLE;
        end
      endcase
    end
  end
endmodule

// ### hw/mac_txrx_regs.vh
// Register indices, field positions and limits of the MAC control block.
`ifndef MAC_TXRX_REGS_VH
`define MAC_TXRX_REGS_VH
`define IDX_TXCTRL 6'h02
`define IDX_TXSTAT1 6'h03
`define IDX_TXSTAT2 6'h04
`define IDX_RXCTRL 6'h05
`define IDX_RXSTAT 6'h06
`define CTRL_RESET 8'h00
`define STAT_RESET 8'h00
`define CTRL_WMASK 8'h7F
`define TXC_JABOFF 6
`define TXC_RETRY 5
`define TXC_S2PAD 4
`define TXC_S2FCS 3
`define TXC_S1PAD 2
`define TXC_S1FCS 1
`define TXC_GO 0
`define RXC_WDOFF 6
`define RXC_DROPLONG 5
`define RXC_DROPFCS 4
`define RXC_ALLMC 3
`define RXC_RUNT 2
`define RXC_PROM 1
`define RXC_EN 0
`define JABBER_BYTES 12'h800
`define WINDOW_BYTES 12'h040
`define MAX_FRAME 12'h5F2
`define BYTES_SAT 12'hFFF
`define BYTES_ZERO 12'h000
`define BYTES_ONE 12'h001
`define COLL_MAX 5'h0F
`define COLL_SAT 5'h10
`define COLL_ZERO 5'h00
`define COLL_ONE 5'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### verification/mac_txrx_asserts.sv
// Port-level checks on the MAC control and status block.
module mac_txrx_asserts (
  input wire clk,
  input wire rst,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire txCollision,
  input wire txRetry,
  input wire txCut,
  input wire txDone,
  input wire rxFrameStart,
  input wire rxActive,
  input wire rxCut,
  input wire rxAccept,
  input wire rxDrop
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking
    @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence wrTake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rdTake;
    arvalid && arready;
  endsequence
  wr_answer_a: assert property (wrTake |-> ##2 bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (rdTake |=> rvalid)
    else $error("read not answered");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  b_busy_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  tx_cut_a: assert property (txCut |-> txDone)
    else $error("cut without done");
  tx_retry_a: assert property (txRetry |-> $past(txCollision))
    else $error("retry without collision");
  rx_start_a: assert property ($rose(rxActive) |-> $past(rxFrameStart))
    else $error("receive began unasked");
  rx_one_a: assert property (rxAccept |-> !rxDrop)
    else $error("accept and drop together");
  rx_cut_a: assert property (rxCut |-> ##[0:1] rxDrop)
    else $error("cut frame not dropped");
endmodule

// ### verification/phy_model.sv
// Behavioural transmit side of the PHY: bytes, collisions and carrier.
module phy_model (
  input wire clk,
  input wire txStart,
  input wire txRetry,
  input wire txDone,
  output logic txByteSent,
  output logic txFrameEnd,
  output logic txCollision,
  output logic carrierPin
);
  timeunit 1ns;
  timeprecision 100ps;
  int nBytes = 10;
  int collAt = -1;
  int collLeft = 0;
  int dropAt = 0;
  int gap = 0;
  int idle = 0;
  int cnt = 0;
  bit carrierUp = 1;
  bit busy = 0;
  initial
  begin
    {txByteSent, txFrameEnd, txCollision, carrierPin} = 4'h0;
  end
  // A slow answer spaces the bytes out by gap idle cycles.
  always @(posedge clk)
  begin
    txByteSent <= 0;
    txFrameEnd <= 0;
    txCollision <= 0;
    if (txStart || txRetry)
    begin
      busy <= 1;
      cnt <= 0;
      carrierPin <= carrierUp;
    end
    else if (txDone)
    begin
      busy <= 0;
      carrierPin <= 0;
    end
    else if (busy && idle > 0)
      idle <= idle - 1;
    else if (busy)
    begin
      idle <= gap;
      if (collLeft > 0 && cnt == collAt)
      begin
        txCollision <= 1;
        collLeft <= collLeft - 1;
        busy <= 0;
      end
      else if (cnt == nBytes)
      begin
        txFrameEnd <= 1;
        busy <= 0;
      end
      else
      begin
        txByteSent <= 1;
        cnt <= cnt + 1;
        if (dropAt > 0 && cnt == dropAt)
          carrierPin <= 0;
      end
    end
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the MAC control and status block.
`include "mac_txrx_regs.vh"
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) \
    begin \
      mismatches++; \
      $display("[FAIL] %0t got %h want %h", $time, a, b); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, symbolErrPin = 0, loopbackOn = 0;
  logic rxFrameStart = 0, rxByteSeen = 0, rxFrameEnd = 0;
  logic rxCollision = 0, rxFifoOverrun = 0, rxGroupAddr = 0;
  logic rxAddrMatch = 0, rxFcsBad = 0, rxDribble = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, txStart, txSlotTwo;
  logic txPadOn, txFcsOn, txRetry, txCut, txDone, rxActive, rxCut;
  logic rxAccept, rxDrop, txByteSent, txFrameEnd, txCollision, carrierPin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, seed = 32'hF56F;
  logic [2:0] txCfg;
  logic rxGot = 0, rxAcc = 0, cutSeen = 0, cutRx = 0;
  int checks = 0, mismatches = 0, dones = 0, frames = 0;
  int txTab[8][7] = '{'{60, -1, 0, 1, 30, 127, 0}, '{100, 63, 1, 1, 0, 127, 0},
    '{100, 64, 2, 1, 0, 127, 0}, '{100, 10, 16, 1, 0, 95, 0},
    '{100, 10, 16, 1, 0, 127, 32}, '{2100, -1, 0, 1, 0, 63, 0},
    '{2100, -1, 0, 1, 0, 127, 64}, '{30, -1, 0, 0, 0, 127, 0}};
  int lens[6] = '{20, 63, 64, 1522, 1523, 2100};
  mac_txrx_control_status DUT (.clk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .carrierPin,
    .symbolErrPin, .loopbackOn, .txByteSent, .txFrameEnd, .txCollision,
    .txStart, .txSlotTwo, .txPadOn, .txFcsOn, .txRetry, .txCut, .txDone,
    .rxFrameStart, .rxByteSeen, .rxFrameEnd, .rxCollision, .rxFifoOverrun,
    .rxGroupAddr, .rxAddrMatch, .rxFcsBad, .rxDribble, .rxActive, .rxCut,
    .rxAccept, .rxDrop);
  phy_model phy (.clk, .txStart, .txRetry, .txDone, .txByteSent,
    .txFrameEnd, .txCollision, .carrierPin);
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (txStart)
      txCfg <= {txSlotTwo, txPadOn, txFcsOn};
    if (txDone)
      dones <= dones + 1;
    if (txDone)
      cutSeen <= txCut;
    if (rxAccept | rxDrop)
      cutRx <= rxCut;
    if (rxAccept | rxDrop)
      rxGot <= 1;
    if (rxAccept | rxDrop)
      rxAcc <= rxAccept;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input [5:0] i, input [7:0] d, input [1:0] r = 0);
    @(posedge clk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    `CHK(bresp, r)
  endtask
  task automatic rd(input [5:0] i, input [7:0] e, input [1:0] r = 0);
    @(posedge clk);
    araddr <= {i, 2'h0};
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    `CHK({rresp, rdata}, {r, 24'h0, e})
  endtask
  task automatic txRun(input int t[7], input bit lb);
    int slot, d0;
    logic [6:0] c;
    logic [7:0] e;
    slot = frames % 2;
    frames++;
    c = (7'(rnd()) & 7'(t[5])) | 7'(t[6]);
    phy.nBytes = t[0];
    phy.collAt = t[1];
    phy.collLeft = t[2];
    phy.carrierUp = t[3];
    phy.dropAt = t[4];
    phy.gap = rnd() & 1;
    loopbackOn <= lb;
    d0 = dones;
    wr(`IDX_TXCTRL, {1'b0, c[6:1], 1'b1});
    for (int k = 0; k < 9000 && dones == d0; k++)
      @(posedge clk);
    e = 0;
    e[3] = t[2] > 0;
    e[4] = t[2] > 0 && t[1] >= 64;
    e[2] = t[2] >= 16 && !c[5];
    e[7] = t[0] > 2048 && !c[6];
    e[5] = !t[3] && !lb;
    e[6] = t[4] > 0 && !lb;
    `CHK(cutSeen, e[7] | e[2])
    `CHK(txCfg, {slot[0], !c[2 * slot + 2], !c[2 * slot + 1]})
    rd(`IDX_TXCTRL, {1'b0, c[6:1], 1'b0});
    rd(6'(`IDX_TXSTAT1 + slot), e);
  endtask
  task automatic rxRun(input int n, input [6:0] c, input [6:0] f);
    bit wd, drop;
    wr(`IDX_RXCTRL, {1'b0, c});
    wd = !c[6] && n > 2048;
    if (n > 2048)
      f = f & 7'h02;
    {rxFcsBad, rxDribble, rxGroupAddr, rxAddrMatch} <= {f[2], f[3], f[0], f[1]};
    symbolErrPin <= f[6];
    rxGot <= 0;
    rxFrameStart <= 1;
    @(posedge clk);
    rxFrameStart <= 0;
    for (int i = 0; i < n; i++)
    begin
      rxByteSeen <= 1;
      rxCollision <= (i == 70) && f[5];
      rxFifoOverrun <= (i == 5) && f[4];
      @(posedge clk);
      {rxByteSeen, rxCollision, rxFifoOverrun} <= 3'h0;
      @(posedge clk);
    end
    rxFrameEnd <= 1;
    @(posedge clk);
    rxFrameEnd <= 0;
    symbolErrPin <= 0;
    repeat (4) @(posedge clk);
    drop = (n > 1522 && c[5]) || (f[2] && c[4]) || (n < 64 && !c[2]) || wd;
    drop |= !(f[1] || c[1] || (f[0] && c[3])) || f[4];
    `CHK(rxGot, c[0])
    if (c[0])
    begin
      `CHK(rxAcc, !drop)
      `CHK(cutRx, wd)
      rd(`IDX_RXSTAT, {n < 64, f[0], f[5] && n > 70, wd, f[6], f[3],
        f[2], f[4]});
    end
  endtask
  initial
  begin
    #400000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 2; i < 8; i++)
      rd(6'(i), 8'h00, (i == 7) ? 2'h2 : 2'h0);
    wr(`IDX_TXSTAT1, 8'hFF);
    wr(6'h07, 8'h01, 2'h2);
    wr(`IDX_RXCTRL, 8'h80);
    rd(`IDX_TXSTAT1, 8'h00);
    rd(`IDX_RXCTRL, 8'h00);
    foreach (txTab[k])
      txRun(txTab[k], 0);
    txRun(txTab[7], 1);
    for (int k = 0; k < 10; k++)
      rxRun(lens[rnd() % 6], 7'(rnd()) | 7'(k > 0), 7'(rnd()));
    conclude();
  end
endmodule
bind mac_txrx_control_status mac_txrx_asserts chk (.clk, .rst, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
  .rdata, .rvalid, .txCollision, .txRetry, .txCut, .txDone, .rxFrameStart,
  .rxActive, .rxCut, .rxAccept, .rxDrop);
